//--- src/orbp_top.sv
// Summary of operation
// R1: One routing word per output, index 01 first
// R2: Software PWM up to 2 kHz, others 500 Hz
// R3: Upper byte source, lower byte control bit
// R4: Bit 7 set makes a zero enable
// R5: Routing word FFFF disables routing of output
// R6: Source 00 constant high, 01 constant low
// R7: Sources 02-08 encoder, 09-0F position steps divided
// R8: Source 10 brake PWM, 11 its inverse
// R9: Divider 1 gives one pulse per increment
// R10: Automatic brake released only when operation enabled; code keeps it released in ST_STOP and ST_WAIT1
// R11: Config bit 2 picks automatic or manual brake
// R12: Enable: current, delay 3, release, delay 4
// R13: Disable: stop, delay 1, engage, delay 2
// R14: Brake PWM frequency accepted only 50 to 20000
// R15: Duty 2 to 100 percent, 100 continuous
// R16: Routing acts only while routing enable set
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "orbp_regs.svh"
module orbp_top #(
    parameter int NOUT = 3,
    parameter int MS_CYCLES = `ORBP_MS_CYCLES,
    parameter int OUT_HALF = `ORBP_HALF_CYCLES(`ORBP_OUT_MAX_HZ),
    parameter int SW_HALF = `ORBP_HALF_CYCLES(`ORBP_SWPWM_MAX_HZ)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire orbp_pkg::orbp_bus_t bus,
    output logic [31:0] rd_data,
    // Increment events from encoder and position
    input wire logic enc_step,
    input wire logic pos_step,
    // Drive state machine
    input wire logic op_enabled,
    input wire logic standstill,
    // Outputs, index 0 is the software PWM output
    output logic [NOUT-1:0] route_out,
    output logic brake_out,
    // Sequencer to drive
    output logic motor_current_on,
    output logic stop_request,
    output logic motion_enable
);
    import orbp_pkg::*;

    localparam int MSW = $clog2(MS_CYCLES) + 1;
    localparam int SW = $clog2(2 * OUT_HALF) + 1;

    orbp_route_t route [NOUT];
    orbp_route_t next_route [NOUT];
    logic [31:0] ctl_word, next_ctl_word;
    logic route_en, next_route_en;
    logic [15:0] drive_cfg, next_drive_cfg;
    logic [15:0] freq, next_freq;
    logic [6:0] duty, next_duty;
    logic [15:0] dly [4];
    logic [15:0] next_dly [4];
    logic [31:0] next_rd_data;
    logic [31:0] status_word;

    orbp_seq_t state, next_state;
    logic [15:0] cnt, next_cnt, step_cnt;
    logic [MSW-1:0] ms_cnt, next_ms_cnt;
    logic tick, done, brake_rel, next_brake_rel, next_brake_out;
    logic next_cur, next_stop, next_men;
    logic pwm;
    logic [6:0] enc_div, pos_div;

    // Divided step streams and brake waveform
    orbp_step_div u_enc_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .step(enc_step),
        .div_pulse(enc_div)
    );
    orbp_step_div u_pos_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .step(pos_step),
        .div_pulse(pos_div)
    );
    orbp_brake_pwm u_pwm (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .freq(freq),
        .duty(duty),
        .pwm(pwm)
    );

    // Bit 4 is spare so the output field stays at [3:0]
    assign status_word = {21'h0, state, brake_out, motion_enable,
                          motor_current_on, 1'b0, 4'(route_out)};

    // Register writes; out-of-range brake PWM settings are dropped
    always_comb
    begin
        next_route = route;
        next_ctl_word = ctl_word;
        next_route_en = route_en;
        next_drive_cfg = drive_cfg;
        next_freq = freq;
        next_duty = duty;
        next_dly = dly;
        if (bus.wr)
        begin
            for (int i = 0; i < NOUT; i++)
                if (bus.addr == 8'(`ORBP_OFS_ROUTE0 + i))
                    next_route[i] = bus.wdata[15:0]; // R1 R3
            for (int j = 0; j < 4; j++)
                if (bus.addr == 8'(`ORBP_OFS_DLY1 + j))
                    next_dly[j] = bus.wdata[15:0];
            if (bus.addr == `ORBP_OFS_CTL)
                next_ctl_word = bus.wdata;
            if (bus.addr == `ORBP_OFS_RTEN)
                next_route_en = bus.wdata[0];
            if (bus.addr == `ORBP_OFS_DRVCFG)
                next_drive_cfg = bus.wdata[15:0];
            if (bus.addr == `ORBP_OFS_FREQ && bus.wdata[31:16] == 16'h0 &&
                bus.wdata[15:0] >= `ORBP_FREQ_MIN &&
                bus.wdata[15:0] <= `ORBP_FREQ_MAX)
                next_freq = bus.wdata[15:0]; // R14
            if (bus.addr == `ORBP_OFS_DUTY && bus.wdata[31:7] == 25'h0 &&
                bus.wdata[6:0] >= `ORBP_DUTY_MIN &&
                bus.wdata[6:0] <= `ORBP_DUTY_MAX)
                next_duty = bus.wdata[6:0]; // R15
        end
    end

    // Read data, stands in the cycle after the strobe only
    always_comb
    begin
        next_rd_data = 32'h0;
        if (bus.rd)
        begin
            for (int i = 0; i < NOUT; i++)
                if (bus.addr == 8'(`ORBP_OFS_ROUTE0 + i))
                    next_rd_data = {16'h0, route[i]};
            for (int j = 0; j < 4; j++)
                if (bus.addr == 8'(`ORBP_OFS_DLY1 + j))
                    next_rd_data = {16'h0, dly[j]};
            if (bus.addr == `ORBP_OFS_CTL)
                next_rd_data = ctl_word;
            if (bus.addr == `ORBP_OFS_RTEN)
                next_rd_data = {31'h0, route_en};
            if (bus.addr == `ORBP_OFS_DRVCFG)
                next_rd_data = {16'h0, drive_cfg};
            if (bus.addr == `ORBP_OFS_FREQ)
                next_rd_data = {16'h0, freq};
            if (bus.addr == `ORBP_OFS_DUTY)
                next_rd_data = {25'h0, duty};
            if (bus.addr == `ORBP_OFS_STATUS)
                next_rd_data = status_word;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NOUT; i++)
                route[i] <= `ORBP_ROUTE_OFF;
            for (int j = 0; j < 4; j++)
                dly[j] <= `ORBP_DLY_RST;
            ctl_word <= 32'h0;
            route_en <= 1'b0;
            drive_cfg <= `ORBP_DRVCFG_RST;
            freq <= `ORBP_FREQ_RST;
            duty <= `ORBP_DUTY_RST;
            rd_data <= 32'h0;
        end
        else
        begin
            route <= next_route;
            dly <= next_dly;
            ctl_word <= next_ctl_word;
            route_en <= next_route_en;
            drive_cfg <= next_drive_cfg;
            freq <= next_freq;
            duty <= next_duty;
            rd_data <= next_rd_data;
        end
    end

    // Brake sequencer; delays count whole milliseconds
    always_comb
    begin
        tick = (ms_cnt == MSW'(MS_CYCLES - 1));
        next_ms_cnt = tick ? '0 : ms_cnt + 1'b1;
        done = (cnt == 16'h0);
        step_cnt = (tick && !done) ? cnt - 16'h1 : cnt;
        next_state = state;
        next_cnt = step_cnt;
        unique case (state)
            ST_HOLD:
                if (op_enabled)
                begin
                    next_state = ST_CUR_ON; // R12
                    next_cnt = dly[2];
                end
            ST_CUR_ON:
                if (!op_enabled)
                begin
                    // Brake still closed, skip the stop and go to the ST_ENGAGE delay before current off
                    next_state = ST_ENGAGE;
                    next_cnt = dly[1];
                end
                else if (done)
                begin
                    next_state = ST_RELEASE; // R12
                    next_cnt = dly[3];
                end
            ST_RELEASE:
                if (!op_enabled)
                    next_state = ST_STOP;
                else if (done)
                    next_state = ST_RUN; // R12
            ST_RUN:
                if (!op_enabled)
                    next_state = ST_STOP; // R13
            ST_STOP:
                if (standstill)
                begin
                    next_state = ST_WAIT1; // R13
                    next_cnt = dly[0];
                end
            ST_WAIT1:
                if (done)
                begin
                    next_state = ST_ENGAGE; // R13
                    next_cnt = dly[1];
                end
            ST_ENGAGE:
                if (done)
                    next_state = ST_HOLD; // R13
            default:
                next_state = ST_HOLD;
        endcase
        next_cur = (next_state != ST_HOLD);
        next_brake_rel = (next_state == ST_RELEASE) ||
                         (next_state == ST_RUN) ||
                         (next_state == ST_STOP) ||
                         (next_state == ST_WAIT1); // R10
        next_men = (next_state == ST_RUN);
        next_stop = (next_state == ST_STOP) || (next_state == ST_WAIT1) ||
                    (next_state == ST_ENGAGE);
        // Manual mode hands the brake to the control word
        next_brake_out = (drive_cfg[`ORBP_BRAKE_AUTO_BIT] ? brake_rel
                          : ctl_word[`ORBP_BRAKE_CTL_BIT]) & pwm; // R11
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state <= ST_HOLD;
            cnt <= 16'h0;
            ms_cnt <= '0;
            brake_rel <= 1'b0;
            brake_out <= 1'b0;
            motor_current_on <= 1'b0;
            stop_request <= 1'b0;
            motion_enable <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            ms_cnt <= next_ms_cnt;
            brake_rel <= next_brake_rel;
            brake_out <= next_brake_out;
            motor_current_on <= next_cur;
            stop_request <= next_stop;
            motion_enable <= next_men;
        end
    end

    // Per-output routing; step sources are stretched to the rate limit
    genvar gi;
    generate
        for (gi = 0; gi < NOUT; gi++)
        begin : g_out
            localparam logic [SW-1:0] HALF =
                SW'((gi == 0) ? SW_HALF : OUT_HALF); // R2
            orbp_route_t w;
            logic [SW-1:0] st, next_st;
            logic gate, ev, stepsrc, normal, pin, next_pin;
            always_comb
            begin
                w = route[gi];
                gate = ((w[6:5] == 2'b00) ? ctl_word[w[4:0]] : 1'b0)
                       ^ w[`ORBP_INV_BIT]; // R3 R4
                normal = (gi == 0) ? 1'b0
                         : ctl_word[`ORBP_OUT1_CTL_BIT + gi - 1];
                stepsrc = 1'b1;
                ev = 1'b0;
                if (w[15:8] >= `ORBP_SRC_ENC1 && w[15:8] <= `ORBP_SRC_ENC64)
                    ev = enc_div[3'(w[15:8] - `ORBP_SRC_ENC1)]; // R7
                else if (w[15:8] >= `ORBP_SRC_POS1 &&
                         w[15:8] <= `ORBP_SRC_POS64)
                    ev = pos_div[3'(w[15:8] - `ORBP_SRC_POS1)]; // R7
                else
                    stepsrc = 1'b0;
                // Events while a pulse is still out are dropped
                next_st = st;
                if (st != '0)
                    next_st = st - 1'b1;
                else if (ev && gate)
                    next_st = SW'(2 * HALF - 1); // R2
                if (!route_en || w == `ORBP_ROUTE_OFF)
                    next_pin = normal; // R5 R16
                else if (stepsrc)
                    next_pin = (st >= HALF);
                else if (w[15:8] == `ORBP_SRC_HIGH)
                    next_pin = gate; // R6
                else if (w[15:8] == `ORBP_SRC_PWM)
                    next_pin = gate & pwm; // R8
                else if (w[15:8] == `ORBP_SRC_PWMN)
                    next_pin = gate & ~pwm; // R8
                else
                    next_pin = 1'b0; // R6
            end
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                begin
                    st <= '0;
                    pin <= 1'b0;
                end
                else
                begin
                    st <= next_st;
                    pin <= next_pin;
                end
            end
            assign route_out[gi] = pin;
        end
    endgenerate

    // Checks on output 1, the lower brake frequency and upper duty limits, the manual brake and the sequencer
    route_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        route_en && route[1] == 16'hffff |=> route_out[1] == $past(ctl_word[16]))
        else $error("disabled route did not follow normal output");
    normal_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R16
        !route_en |=> route_out[1] == $past(ctl_word[16]))
        else $error("output not normal with routing off");
    const_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
        route_en && route[1][15:7] == 9'h000 && ctl_word[route[1][4:0]] &&
        route[1][6:5] == 2'b00 |=> route_out[1])
        else $error("constant high source not high");
    const_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
        route_en && route[1][15:8] == 8'h01 |=> !route_out[1])
        else $error("constant low source not low");
    invert_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        route_en && route[1][15:7] == 9'h001 && ctl_word[route[1][4:0]] &&
        route[1][6:5] == 2'b00 |=> !route_out[1])
        else $error("inverted control bit did not switch off");
    freq_reject_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        bus.wr && bus.addr == 8'h13 && bus.wdata < 32'h32 |=> $stable(freq))
        else $error("illegal brake frequency accepted");
    duty_reject_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
        bus.wr && bus.addr == 8'h14 && bus.wdata > 32'h64 |=> $stable(duty))
        else $error("illegal brake duty accepted");
    brake_manual_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
        !drive_cfg[2] && !ctl_word[0] |=> !brake_out)
        else $error("manual brake output on with bit 0 clear");
    brake_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
        brake_rel |-> motor_current_on && state != ST_HOLD)
        else $error("brake released without current");
    run_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
        $rose(motion_enable) |-> $past(brake_rel))
        else $error("motion enabled before brake release");
    drop_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        state == ST_RUN && !op_enabled |=> stop_request && !motion_enable)
        else $error("leaving operation enabled did not stop");
    run_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_RUN);
    back_hold_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state == ST_ENGAGE ##1 state == ST_HOLD);
    step_out_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        route_en && $rose(route_out[1]));
    brake_pwm_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(brake_out));

endmodule : orbp_top

//--- shared/orbp_regs.svh
`ifndef ORBP_REGS_SVH
`define ORBP_REGS_SVH

// Register offsets (word index on the plain register port)
`define ORBP_OFS_ROUTE0 8'h01
`define ORBP_OFS_CTL 8'h10
`define ORBP_OFS_RTEN 8'h11
`define ORBP_OFS_DRVCFG 8'h12
`define ORBP_OFS_FREQ 8'h13
`define ORBP_OFS_DUTY 8'h14
`define ORBP_OFS_DLY1 8'h15
`define ORBP_OFS_STATUS 8'h19

// Routing word fields and source codes
`define ORBP_ROUTE_OFF 16'hffff
`define ORBP_INV_BIT 7
`define ORBP_SRC_HIGH 8'h00
`define ORBP_SRC_LOW 8'h01
`define ORBP_SRC_ENC1 8'h02
`define ORBP_SRC_ENC64 8'h08
`define ORBP_SRC_POS1 8'h09
`define ORBP_SRC_POS64 8'h0f
`define ORBP_SRC_PWM 8'h10
`define ORBP_SRC_PWMN 8'h11

// Control and configuration bit positions
`define ORBP_BRAKE_AUTO_BIT 2
`define ORBP_BRAKE_CTL_BIT 0
`define ORBP_OUT1_CTL_BIT 16

// Brake PWM limits and reset values
`define ORBP_FREQ_MIN 16'h0032
`define ORBP_FREQ_MAX 16'h4e20
`define ORBP_DUTY_MIN 7'h02
`define ORBP_DUTY_MAX 7'h64
`define ORBP_FREQ_RST 16'h07d0
`define ORBP_DUTY_RST 7'h64
`define ORBP_DRVCFG_RST 16'h0004
`define ORBP_DLY_RST 16'h0000

// Timing
`define ORBP_CLK_PERIOD_NS 10
`define ORBP_CLK_HZ 100000000
`define ORBP_MS_NS 1000000
`define ORBP_MS_CYCLES (`ORBP_MS_NS / `ORBP_CLK_PERIOD_NS)
`define ORBP_OUT_MAX_HZ 500
`define ORBP_SWPWM_MAX_HZ 2000
`define ORBP_HALF_CYCLES(hz) (`ORBP_CLK_HZ / (2 * (hz)))

`endif

//--- shared/orbp_pkg.sv
package orbp_pkg;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } orbp_bus_t;

    typedef logic [15:0] orbp_route_t;

    // Brake sequencer states
    typedef enum logic [2:0] {
        ST_HOLD = 3'h0,
        ST_CUR_ON = 3'h1,
        ST_RELEASE = 3'h2,
        ST_RUN = 3'h3,
        ST_STOP = 3'h4,
        ST_WAIT1 = 3'h5,
        ST_ENGAGE = 3'h6
    } orbp_seq_t;

endpackage : orbp_pkg

//--- src/orbp_step_div.sv
`timescale 1ns/1ns
module orbp_step_div (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Increment events, one cycle each
    input wire logic step,
    // Divided pulses for dividers 1, 2, 4 ... 64
    output logic [6:0] div_pulse
);
    import orbp_pkg::*;

    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic [6:0] next_div;

    // Divider 2^k fires when the low k count bits are all ones
    genvar k;
    generate
        for (k = 0; k < 7; k++)
        begin : g_div
            localparam logic [5:0] MASK = 6'((1 << k) - 1);
            assign next_div[k] = step && ((cnt | ~MASK) == 6'h3f); // R9
        end
    endgenerate

    // Step counter
    always_comb
    begin
        next_cnt = step ? cnt + 6'h01 : cnt;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cnt <= 6'h00;
            div_pulse <= 7'h00;
        end
        else
        begin
            cnt <= next_cnt;
            div_pulse <= next_div;
        end
    end

    step_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
        step |=> div_pulse[0])
        else $error("step did not give a divide-by-1 pulse");
    step_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
        !step |=> div_pulse == 7'h00)
        else $error("divided pulse without a step");

endmodule : orbp_step_div

//--- src/orbp_brake_pwm.sv
`timescale 1ns/1ns
`include "orbp_regs.svh"
module orbp_brake_pwm #(
    parameter int CLK_HZ = `ORBP_CLK_HZ
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Frequency in Hz and duty in percent
    input wire logic [15:0] freq,
    input wire logic [6:0] duty,
    // Waveform
    output logic pwm
);
    import orbp_pkg::*;

    localparam logic [26:0] CLK_LIM = 27'(CLK_HZ);

    logic [26:0] acc;
    logic [26:0] next_acc;
    logic [27:0] sum;
    logic next_pwm;

    // Phase accumulator: no divider needed, period is exact on average
    always_comb
    begin
        sum = {1'b0, acc} + {12'h000, freq};
        next_acc = (sum >= {1'b0, CLK_LIM}) ? 27'(sum - {1'b0, CLK_LIM})
                                             : sum[26:0];
        // High share of the phase; duty 100 is always high
        next_pwm = ({7'h00, acc} * 34'h64) <
                   (34'(CLK_HZ) * {27'h0, duty}); // R8 R15
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            acc <= 27'h0;
            pwm <= 1'b0;
        end
        else
        begin
            acc <= next_acc;
            pwm <= next_pwm;
        end
    end

    duty_full_a: assert property (@(posedge ref_clk) // R15
        disable iff (!rst_n) duty == `ORBP_DUTY_MAX |=> pwm)
        else $error("full duty not continuously on");
    phase_range_a: assert property (@(posedge ref_clk) // R8
        disable iff (!rst_n) acc < CLK_LIM)
        else $error("phase accumulator out of range");

endmodule : orbp_brake_pwm

//--- sim/orbp_load_model.sv
`timescale 1ns/1ns
module orbp_load_model (
    // Clock and count clear
    input wire logic ref_clk,
    input wire logic clear,
    // Load drive levels
    input wire logic [2:0] route_out,
    input wire logic brake_out,
    // Energised cycles per load, index 3 is the brake
    output logic [3:0][15:0] on_cnt
);
    logic [3:0] lv;

    // Loads only sink current; nothing is driven back
    assign lv = {brake_out, route_out};

    // On-time integration, cleared per measurement window
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (clear)
                on_cnt[i] <= 16'h0000;
            else
                on_cnt[i] <= on_cnt[i] + {15'h0000, lv[i]};
        end
    end
endmodule : orbp_load_model

//--- sim/orbp_top_tb.sv
`timescale 1ns/1ns
module orbp_top_tb;
    import orbp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    orbp_bus_t bus = '0;
    logic [31:0] rd_data;
    logic enc_step = 1'b0;
    logic pos_step = 1'b0;
    logic op_enabled = 1'b0;
    logic standstill = 1'b0;
    logic [2:0] route_out;
    logic brake_out;
    logic motor_current_on;
    logic stop_request;
    logic motion_enable;
    logic clear = 1'b1;
    logic [3:0][15:0] on_cnt;
    int bad_count = 0;
    int check_count = 0;
    int n;

    always #5 ref_clk = ~ref_clk;

    // Short ms tick and pulse halves keep the run brief
    orbp_top #(.NOUT(3), .MS_CYCLES(10), .OUT_HALF(8), .SW_HALF(4)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
        .enc_step(enc_step), .pos_step(pos_step), .op_enabled(op_enabled),
        .standstill(standstill), .route_out(route_out),
        .brake_out(brake_out), .motor_current_on(motor_current_on),
        .stop_request(stop_request), .motion_enable(motion_enable));
    orbp_load_model load (.ref_clk(ref_clk), .clear(clear),
        .route_out(route_out), .brake_out(brake_out), .on_cnt(on_cnt));

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic span(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask : span

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 check(rd_data, exp);
        @(posedge ref_clk);
        #1 check(rd_data, 32'h0);
    endtask : rd

    // Bounded wait for a level: 0 brake, 1 motion, 2 current
    task automatic wait_for(input int sel, input logic v, output int c);
        logic s;
        c = 0;
        do
        begin
            @(posedge ref_clk);
            #1 s = sel == 0 ? brake_out : sel == 1 ? motion_enable
                : motor_current_on;
            c++;
        end while (s !== v && c < 200);
        if (c >= 200)
        begin
            bad_count++;
            conclude();
        end
    endtask : wait_for

    // Steps on both sources, gap+1 idle cycles after each when gap is nonzero
    task automatic pulses(input int cnt, input int gap);
        @(posedge ref_clk);
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        repeat (cnt)
        begin
            @(posedge ref_clk);
            {enc_step, pos_step} <= 2'b11;
            if (gap > 0)
            begin
                @(posedge ref_clk);
                {enc_step, pos_step} <= 2'b00;
                repeat (gap) @(posedge ref_clk);
            end
        end
        @(posedge ref_clk);
        {enc_step, pos_step} <= 2'b00;
        repeat (24) @(posedge ref_clk);
    endtask : pulses

    task automatic t_regs();
        for (int i = 1; i < 4; i++)
            rd(8'(i), 32'h0000ffff);
        rd(8'h12, 32'h4);
        rd(8'h40, 32'h0);
        $display("regs done");
    endtask : t_regs

    task automatic t_limits();
        logic [7:0] a [8] = '{8'h13, 8'h13, 8'h13, 8'h13,
            8'h14, 8'h14, 8'h14, 8'h14};
        logic [31:0] d [8] = '{32'h31, 32'h32, 32'h4e21, 32'h4e20,
            32'h01, 32'h65, 32'h02, 32'h64};
        logic [31:0] e [8] = '{32'h7d0, 32'h32, 32'h32, 32'h4e20,
            32'h64, 32'h64, 32'h02, 32'h64};
        for (int i = 0; i < 8; i++)
        begin
            wr(a[i], d[i]);
            rd(a[i], e[i]);
        end
        $display("limits done");
    endtask : t_limits

    task automatic t_route();
        logic re [9] = '{1, 1, 1, 1, 1, 1, 1, 0, 0};
        logic [15:0] rw [9] = '{16'h0005, 16'h0005, 16'h0085, 16'h0085,
            16'h0105, 16'hffff, 16'hffff, 16'h0005, 16'h0005};
        logic [31:0] rc [9] = '{32'h20, 32'h0, 32'h20, 32'h0, 32'h20,
            32'h10000, 32'h0, 32'h10000, 32'h20};
        logic rx [9] = '{1, 0, 0, 1, 0, 1, 0, 1, 0};
        for (int i = 0; i < 9; i++)
        begin
            wr(8'h11, {31'h0, re[i]});
            wr(8'h02, {16'h0, rw[i]});
            wr(8'h10, rc[i]);
            repeat (3) @(posedge ref_clk);
            #1 check(route_out[1], rx[i]);
        end
        $display("route done");
    endtask : t_route

    task automatic t_steps();
        wr(8'h11, 32'h1);
        wr(8'h10, 32'h2);
        for (int k = 0; k < 7; k++)
        begin
            wr(8'h01, {16'h0, 8'(9 + k), 8'h01});
            wr(8'h02, {16'h0, 8'(2 + k), 8'h01});
            pulses(64, 16);
            check(on_cnt[0], (64 >> k) * 4);
            check(on_cnt[1], (64 >> k) * 8);
        end
        wr(8'h01, 32'h0901);
        wr(8'h02, 32'h0201);
        pulses(4, 0);
        check(on_cnt[0], 4);
        check(on_cnt[1], 8);
        $display("steps done");
    endtask : t_steps

    task automatic t_pwm();
        wr(8'h10, 32'h0);
        wr(8'h03, 32'h1080);
        repeat (3) @(posedge ref_clk);
        #1 check(route_out[2], 1);
        wr(8'h03, 32'h1180);
        repeat (3) @(posedge ref_clk);
        #1 check(route_out[2], 0);
        wr(8'h03, 32'h1080);
        wr(8'h14, 32'h19);
        pulses(0, 0);
        repeat (9976) @(posedge ref_clk);
        span(on_cnt[2], 2450, 2550);
        $display("pwm done");
    endtask : t_pwm

    task automatic t_brake();
        wr(8'h14, 32'h64);
        wr(8'h10, 32'h1);
        repeat (4) @(posedge ref_clk);
        #1 check(brake_out, 0);
        wr(8'h12, 32'h0);
        repeat (4) @(posedge ref_clk);
        #1 check(brake_out, 1);
        wr(8'h10, 32'h0);
        repeat (4) @(posedge ref_clk);
        #1 check(brake_out, 0);
        wr(8'h12, 32'h4);
        for (int i = 5; i < 9; i++)
            wr(8'(16 + i), 32'h2);
        op_enabled <= 1'b1;
        wait_for(2, 1, n);
        span(n, 1, 3);
        check(brake_out, 0);
        wait_for(0, 1, n);
        span(n, 9, 24);
        check(motion_enable, 0);
        wait_for(1, 1, n);
        span(n, 9, 24);
        rd(8'h19, 32'h000003e4);
        op_enabled <= 1'b0;
        repeat (30) @(posedge ref_clk);
        #1 check({brake_out, stop_request, motion_enable}, 3'b110);
        standstill <= 1'b1;
        wait_for(0, 0, n);
        span(n, 9, 24);
        check(motor_current_on, 1);
        wait_for(2, 0, n);
        span(n, 9, 24);
        $display("brake done");
    endtask : t_brake

    // Main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_limits();
        t_route();
        t_steps();
        t_pwm();
        t_brake();
        conclude();
    end
endmodule : orbp_top_tb
